// ===== hw/compact_timer_module_regs.sv
// Compact 10-bit timer: register file, count clock choice, counter,
// period and compare-A comparators, event interrupt.
// Assumes one clock mclk; tick inputs are one-cycle pulses on mclk.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module compact_timer_module_regs (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ctm_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ctm_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Count clock sources
  input wire logic hiClkTick,
  input wire logic timebaseTick,
  input wire logic externalCountIn,
  // Timer output and interrupt
  output logic timerOutputPin,
  output logic irq
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [ctm_pkg::CNT_W-1:0] count_r;
  logic [ctm_pkg::CNT_W-1:0] count_nxt;
  logic [ctm_pkg::CNT_W-1:0] cmpA_r;
  logic [7:0] lowBuf_r;
  logic [ctm_pkg::EV_W-1:0] intStat_r;
  logic [ctm_pkg::EV_W-1:0] intMask_r;
  logic [ctm_pkg::SYS_DIV_W-1:0] sysDiv_r;
  logic [ctm_pkg::HI_DIV64_W-1:0] hiDiv_r;
  logic [2:0] extSync_r;
  logic onDly_r;
  logic pin_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [ctm_pkg::ADDR_W-1:0] awAddr_r;
  logic [7:0] wByte_r;
  logic wLane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic countPause;
  logic timerOn;
  logic counterClearSourceSelect;
  logic outputInitialLevel;
  logic [2:0] periodCompareField;
  ctm_pkg::clk_sel_t countClockSelect;
  ctm_pkg::op_mode_t operatingModeSelect;
  ctm_pkg::io_act_t pinAction;
  logic tick;
  logic advance;
  logic onRise;
  logic [ctm_pkg::CNT_W-1:0] incr;
  logic periodMatch;
  logic cmpAMatch;
  logic overflow;
  logic doWrite;
  logic rdTake;
  logic [ctm_pkg::EV_W-1:0] events;

  assign countPause = ctrl0_r[ctm_pkg::PAUSE_BIT];
  assign countClockSelect =
    ctm_pkg::clk_sel_t'(ctrl0_r[ctm_pkg::CKSEL_LSB +: 3]);
  assign timerOn = ctrl0_r[ctm_pkg::ON_BIT];
  assign periodCompareField = ctrl0_r[ctm_pkg::PER_LSB +: 3];
  assign operatingModeSelect =
    ctm_pkg::op_mode_t'(ctrl1_r[ctm_pkg::MODE_LSB +: 2]);
  assign pinAction = ctm_pkg::io_act_t'(ctrl1_r[ctm_pkg::IO_LSB +: 2]);
  assign outputInitialLevel = ctrl1_r[ctm_pkg::INIT_BIT];
  assign counterClearSourceSelect = ctrl1_r[ctm_pkg::CLRSEL_BIT];

  // ****************************************************************
  // Count clock selection
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sysDiv_r <= '0;
    end else if (clkEn) begin
      sysDiv_r <= sysDiv_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hiDiv_r <= '0;
    end else if (clkEn && hiClkTick) begin
      hiDiv_r <= hiDiv_r + 1'b1;
    end
  end

  // Stage 0 only feeds stage 1; edges are seen on stages 1 and 2
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      extSync_r <= '0;
    end else if (clkEn) begin
      extSync_r <= {extSync_r[1:0], externalCountIn};
    end
  end

  always_comb begin
    unique case (countClockSelect)
      ctm_pkg::CK_SYS_DIV4: tick = &sysDiv_r;
      ctm_pkg::CK_SYS: tick = 1'b1;
      ctm_pkg::CK_HI_DIV16:
        tick = hiClkTick && (&hiDiv_r[ctm_pkg::HI_DIV16_W-1:0]);
      ctm_pkg::CK_HI_DIV64: tick = hiClkTick && (&hiDiv_r);
      ctm_pkg::CK_TIMEBASE: tick = timebaseTick;
      ctm_pkg::CK_RESERVED: tick = 1'b0;
      ctm_pkg::CK_EXT_RISE: tick = extSync_r[1] && !extSync_r[2];
      ctm_pkg::CK_EXT_FALL: tick = !extSync_r[1] && extSync_r[2];
    endcase
  end

  // ****************************************************************
  // Counter and comparators
  // ****************************************************************
  // On-edge detector; its delay flop freezes with the rest
  assign onRise = timerOn && !onDly_r;
  assign advance = tick && timerOn && !countPause;
  assign incr = count_r + 1'b1;
  // Match lands on the count that would equal the compare value
  always_comb begin
    if (periodCompareField == '0) begin
      periodMatch = advance && (&count_r);
    end else begin
      periodMatch = advance && (incr[ctm_pkg::CNT_W-1:ctm_pkg::PER_SHIFT]
        == periodCompareField) && (incr[ctm_pkg::PER_SHIFT-1:0] == '0);
    end
  end
  assign cmpAMatch = advance && (incr == cmpA_r);
  // Wrap at the top flags a period event whatever clears the count
  assign overflow = advance && (&count_r);
  assign events = {cmpAMatch, periodMatch || overflow};

  always_comb begin
    count_nxt = count_r;
    if (onRise) begin
      count_nxt = '0;
    end else if (periodMatch && !counterClearSourceSelect) begin
      count_nxt = '0;
    end else if (cmpAMatch && counterClearSourceSelect) begin
      count_nxt = '0;
    end else if (advance) begin
      count_nxt = incr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_r <= '0;
      onDly_r <= 1'b0;
    end else if (clkEn) begin
      count_r <= count_nxt;
      onDly_r <= timerOn;
    end
  end

  // Pin reaction beyond initial level is limited to compare-A actions
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_r <= 1'b0;
    end else if (clkEn
        && operatingModeSelect == ctm_pkg::MODE_COMPARE) begin
      if (onRise) begin
        pin_r <= outputInitialLevel;
      end else if (cmpAMatch) begin
        unique case (pinAction)
          ctm_pkg::IO_KEEP: pin_r <= pin_r;
          ctm_pkg::IO_LOW: pin_r <= 1'b0;
          ctm_pkg::IO_HIGH: pin_r <= 1'b1;
          ctm_pkg::IO_TOGGLE: pin_r <= !pin_r;
        endcase
      end
    end
  end
  assign timerOutputPin = pin_r;

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Readies gated by clkEn so nothing is taken while state is frozen
  assign awready = clkEn && !awHeld_r && !bvalid_r;
  assign wready = clkEn && !wHeld_r && !bvalid_r;
  assign doWrite = clkEn && awHeld_r && wHeld_r && !bvalid_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r <= 1'b0;
      wByte_r <= '0;
      wLane_r <= 1'b0;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wByte_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= ctm_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        bvalid_r <= 1'b1;
        unique case (awAddr_r)
          ctm_pkg::OFF_CTRL0, ctm_pkg::OFF_CTRL1, ctm_pkg::OFF_CNT_LO,
          ctm_pkg::OFF_CNT_HI, ctm_pkg::OFF_CMPA_LO,
          ctm_pkg::OFF_CMPA_HI, ctm_pkg::OFF_INT_STAT,
          ctm_pkg::OFF_INT_MASK: bresp_r <= ctm_pkg::RESP_OKAY;
          default: bresp_r <= ctm_pkg::RESP_SLVERR;
        endcase
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctrl0_r <= ctm_pkg::CTRL_RESET;
      ctrl1_r <= ctm_pkg::CTRL_RESET;
      intMask_r <= '0;
      cmpA_r <= '0;
    end else if (clkEn && doWrite && wLane_r) begin
      unique case (awAddr_r)
        ctm_pkg::OFF_CTRL0: ctrl0_r <= wByte_r;
        ctm_pkg::OFF_CTRL1: ctrl1_r <= wByte_r;
        ctm_pkg::OFF_INT_MASK: intMask_r <= wByte_r[ctm_pkg::EV_W-1:0];
        ctm_pkg::OFF_CMPA_HI:
          cmpA_r <= {wByte_r[ctm_pkg::HI_W-1:0], lowBuf_r};
        default: ;
      endcase
    end
  end

  // One buffer shared by counter and compare-A low bytes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lowBuf_r <= '0;
    end else if (clkEn) begin
      if (doWrite && wLane_r && awAddr_r == ctm_pkg::OFF_CMPA_LO) begin
        lowBuf_r <= wByte_r;
      end else if (rdTake && araddr == ctm_pkg::OFF_CNT_HI) begin
        lowBuf_r <= count_r[7:0];
      end else if (rdTake && araddr == ctm_pkg::OFF_CMPA_HI) begin
        lowBuf_r <= cmpA_r[7:0];
      end
    end
  end

  // Event set wins over a same-cycle write-one-to-clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      intStat_r <= '0;
    end else if (clkEn) begin
      if (doWrite && wLane_r && awAddr_r == ctm_pkg::OFF_INT_STAT) begin
        intStat_r <= (intStat_r & ~wByte_r[ctm_pkg::EV_W-1:0]) | events;
      end else begin
        intStat_r <= intStat_r | events;
      end
    end
  end
  assign irq = |(intStat_r & intMask_r);

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // One read in flight; its answer must be taken before the next
  assign arready = clkEn && !rvalid_r;
  assign rdTake = arvalid && arready;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= ctm_pkg::RESP_OKAY;
    end else if (clkEn) begin
      if (rdTake) begin
        rvalid_r <= 1'b1;
        rdata_r <= '0;
        rresp_r <= ctm_pkg::RESP_OKAY;
        unique case (araddr)
          ctm_pkg::OFF_CTRL0: rdata_r[7:0] <= ctrl0_r;
          ctm_pkg::OFF_CTRL1: rdata_r[7:0] <= ctrl1_r;
          ctm_pkg::OFF_CNT_LO, ctm_pkg::OFF_CMPA_LO:
            rdata_r[7:0] <= lowBuf_r;
          ctm_pkg::OFF_CNT_HI:
            rdata_r[ctm_pkg::HI_W-1:0] <=
              count_r[ctm_pkg::CNT_W-1 -: ctm_pkg::HI_W];
          ctm_pkg::OFF_CMPA_HI:
            rdata_r[ctm_pkg::HI_W-1:0] <=
              cmpA_r[ctm_pkg::CNT_W-1 -: ctm_pkg::HI_W];
          ctm_pkg::OFF_INT_STAT:
            rdata_r[ctm_pkg::EV_W-1:0] <= intStat_r;
          ctm_pkg::OFF_INT_MASK:
            rdata_r[ctm_pkg::EV_W-1:0] <= intMask_r;
          default: rresp_r <= ctm_pkg::RESP_SLVERR;
        endcase
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

endmodule : compact_timer_module_regs
`default_nettype wire

// ===== hw/ctm_pkg.sv
// Constants for the compact 10-bit timer register block.
// Assumes a 32-bit AXI4-Lite slave with one byte register per word.
package ctm_pkg;
  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL0 = 5'h00;
  localparam logic [4:0] OFF_CTRL1 = 5'h04;
  localparam logic [4:0] OFF_CNT_LO = 5'h08;
  localparam logic [4:0] OFF_CNT_HI = 5'h0C;
  localparam logic [4:0] OFF_CMPA_LO = 5'h10;
  localparam logic [4:0] OFF_CMPA_HI = 5'h14;
  localparam logic [4:0] OFF_INT_STAT = 5'h18;
  localparam logic [4:0] OFF_INT_MASK = 5'h1C;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CNT_W = 10;
  localparam int HI_W = 2;
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam int PER_LSB = 0;
  localparam int MODE_LSB = 6;
  localparam int IO_LSB = 4;
  localparam int INIT_BIT = 3;
  localparam int CLRSEL_BIT = 0;
  localparam int PER_SHIFT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int EV_PERIOD = 0;
  localparam int EV_CMPA = 1;
  localparam int EV_W = 2;
  // ****************************************************************
  // Prescalers and encodings
  // ****************************************************************
  localparam int SYS_DIV_W = 2;
  localparam int HI_DIV16_W = 4;
  localparam int HI_DIV64_W = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'b000,
    CK_SYS = 3'b001,
    CK_HI_DIV16 = 3'b010,
    CK_HI_DIV64 = 3'b011,
    CK_TIMEBASE = 3'b100,
    CK_RESERVED = 3'b101,
    CK_EXT_RISE = 3'b110,
    CK_EXT_FALL = 3'b111
  } clk_sel_t;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } op_mode_t;
  typedef enum logic [1:0] {
    IO_KEEP = 2'b00,
    IO_LOW = 2'b01,
    IO_HIGH = 2'b10,
    IO_TOGGLE = 2'b11
  } io_act_t;
endpackage : ctm_pkg

// ===== dv/compact_timer_module_regs_asserts.sv
// Bus and readback checks for the compact timer register block.
// Bound to compact_timer_module_regs; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module compact_timer_module_regs_asserts (
  // Clock and control
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ctm_pkg::ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence sBothTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence sReadTaken;
    arvalid && arready;
  endsequence
  chk_write_answer: assert property (sBothTaken |=> !bvalid ##1 bvalid)
    else $error("write answer not two edges after request");
  chk_read_answer: assert property (sReadTaken |=> rvalid)
    else $error("read answer not one edge after request");
  chk_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer stands after acceptance");
  chk_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer stands after acceptance");
  chk_ar_refuse: assert property (rvalid |-> !arready)
    else $error("read address taken while answer pending");
  chk_aw_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  chk_clken_stall: assert property (!clkEn |-> !(awready || wready || arready))
    else $error("bus ready while clock enable low");
  chk_hi_zero: assert property (sReadTaken ##0 (araddr == ctm_pkg::OFF_CNT_HI
      || araddr == ctm_pkg::OFF_CMPA_HI) |=> rdata[31:2] == '0)
    else $error("high byte unused bits not zero");
  chk_lane_zero: assert property (rvalid |-> rdata[31:8] == '0)
    else $error("read data above byte lane not zero");
endmodule : compact_timer_module_regs_asserts
bind compact_timer_module_regs compact_timer_module_regs_asserts
  compact_timer_module_regs_asserts_inst (.mclk, .reset_n, .clkEn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .araddr,
  .rvalid, .rready, .rdata);
`default_nettype wire

// ===== dv/compact_timer_module_regs_bench.sv
// Self-checking bench for the compact timer register block.
// Drives AXI4-Lite and the tick inputs directly; no far-side model.
`timescale 1ns/10ps
`default_nettype none
module compact_timer_module_regs_bench;
  logic mclk, reset_n, clkEn, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, hiClkTick, timebaseTick;
  logic externalCountIn, timerOutputPin, irq;
  logic [4:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, rd, c1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] wResp, rResp;
  int bad_count, tests_run;
  logic [2:0] ckCode [6] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h5};
  int ckSrc [6] = '{1, 1, 2, 4, 4, 7};
  int ckN [6] = '{32, 64, 5, 6, 7, 9};
  int ckExp [6] = '{2, 1, 5, 6, 7, 0};
  logic [7:0] ioCfg [3] = '{8'h21, 8'h09, 8'h39};
  logic ioExp [3] = '{1'b1, 1'b1, 1'b0};
  compact_timer_module_regs compact_timer_module_regs_inst (.mclk, .reset_n,
    .clkEn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .hiClkTick, .timebaseTick,
    .externalCountIn, .timerOutputPin, .irq);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // ****************************************************************
  // Bus cycles: sample at falling edge, act after rising edge
  // ****************************************************************
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic awHs, wHs, bHs;
    bHs = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bHs) begin
      @(negedge mclk);
      awHs = awvalid && awready;
      wHs = wvalid && wready;
      bHs = bvalid && bready;
      wResp = bresp;
      @(posedge mclk);
      if (awHs) awvalid <= 1'b0;
      if (wHs) wvalid <= 1'b0;
      if (bHs) bready <= 1'b0;
    end
  endtask : wr
  task automatic rdReg(input logic [4:0] a, output logic [31:0] d);
    logic arHs, rHs;
    rHs = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rHs) begin
      @(negedge mclk);
      arHs = arvalid && arready;
      rHs = rvalid && rready;
      d = rdata;
      rResp = rresp;
      @(posedge mclk);
      if (arHs) arvalid <= 1'b0;
      if (rHs) rready <= 1'b0;
    end
  endtask : rdReg
  // High byte first so the low byte comes from the latched buffer
  task automatic rdCount(output logic [31:0] d);
    logic [31:0] h, l;
    rdReg(ctm_pkg::OFF_CNT_HI, h);
    rdReg(ctm_pkg::OFF_CNT_LO, l);
    d = (h << 8) | l;
  endtask : rdCount
  // Source mask: 1 high clock, 2 timebase, 4 pin
  task automatic pulse(input int src, input int n);
    repeat (n) begin
      @(posedge mclk);
      hiClkTick <= src[0];
      timebaseTick <= src[1];
      externalCountIn <= src[2];
      @(posedge mclk);
      {hiClkTick, timebaseTick, externalCountIn} <= 3'h0;
    end
    repeat (5) @(posedge mclk);
  endtask : pulse
  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    #4000000;
    bad_count++;
    end_sim();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {hiClkTick, timebaseTick, externalCountIn, reset_n} = 4'h0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hF;
    clkEn = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdReg(5'(i * 4), rd);
      check("reset value", 32'h0, rd);
      check("read response", 32'h0, 32'(rResp));
    end
    wr(5'h02, 8'hFF);
    check("bad wr resp", 32'(ctm_pkg::RESP_SLVERR), 32'(wResp));
    rdReg(5'h02, rd);
    check("bad rd resp", 32'(ctm_pkg::RESP_SLVERR), 32'(rResp));
    check("bad rd data", 32'h0, rd);
    for (int i = 0; i < 6; i++) begin
      wr(ctm_pkg::OFF_CTRL0, {1'b0, ckCode[i], 4'h8});
      pulse(ckSrc[i], ckN[i]);
      rdCount(rd);
      check("count per source", 32'(ckExp[i]), rd);
      wr(ctm_pkg::OFF_CTRL0, 8'h00);
    end
    wr(ctm_pkg::OFF_CTRL0, 8'h18);
    repeat (20) @(posedge mclk);
    wr(ctm_pkg::OFF_CTRL0, 8'h98);
    rdCount(c1);
    repeat (10) @(posedge mclk);
    rdCount(rd);
    check("paused count", c1, rd);
    check("system count ran", 32'h1, 32'(c1 > 16));
    // Snapshots 44 edges apart see exactly 11 quarter-rate ticks
    wr(ctm_pkg::OFF_CTRL0, 8'h08);
    rdCount(c1);
    repeat (38) @(posedge mclk);
    rdCount(rd);
    check("quarter rate", c1 + 32'hB, rd);
    wr(ctm_pkg::OFF_CTRL0, 8'h40);
    wr(ctm_pkg::OFF_CTRL0, 8'h48);
    pulse(2, 3);
    wr(ctm_pkg::OFF_CTRL0, 8'hC8);
    pulse(2, 4);
    wr(ctm_pkg::OFF_CTRL0, 8'h48);
    clkEn <= 1'b0;
    pulse(2, 4);
    clkEn <= 1'b1;
    pulse(2, 2);
    rdCount(rd);
    check("resumed count", 32'h5, rd);
    wr(ctm_pkg::OFF_CTRL0, 8'h40);
    pulse(2, 3);
    rdCount(rd);
    check("off holds", 32'h5, rd);
    wr(ctm_pkg::OFF_CTRL0, 8'h48);
    rdCount(rd);
    check("on clears", 32'h0, rd);
    wr(ctm_pkg::OFF_CNT_LO, 8'h77);
    wr(ctm_pkg::OFF_CNT_HI, 8'h03);
    rdCount(rd);
    check("count read only", 32'h0, rd);
    wr(ctm_pkg::OFF_INT_MASK, 8'h01);
    for (int p = 0; p < 8; p++) begin
      wr(ctm_pkg::OFF_CTRL0, 8'h40);
      wr(ctm_pkg::OFF_INT_STAT, 8'h03);
      check("irq cleared", 32'h0, {31'h0, irq});
      wr(ctm_pkg::OFF_CTRL0, {5'h09, 3'(p)});
      pulse(2, (p == 0 ? 1024 : p * 128) + 2);
      rdCount(rd);
      check("period wrap", 32'h2, rd);
      check("period irq", 32'h1, {31'h0, irq});
    end
    wr(ctm_pkg::OFF_CTRL0, 8'h40);
    wr(ctm_pkg::OFF_INT_MASK, 8'h00);
    check("irq masked", 32'h0, {31'h0, irq});
    rdReg(ctm_pkg::OFF_INT_STAT, rd);
    check("status kept", 32'h1, rd & 32'h1);
    wr(ctm_pkg::OFF_CMPA_LO, 8'hA5);
    wr(ctm_pkg::OFF_CMPA_HI, 8'hFF);
    check("write response", 32'h0, 32'(wResp));
    rdReg(ctm_pkg::OFF_CNT_HI, rd);
    rdReg(ctm_pkg::OFF_CMPA_HI, rd);
    check("compare high", 32'h3, rd);
    rdReg(ctm_pkg::OFF_CMPA_LO, rd);
    check("compare low", 32'hA5, rd);
    wr(ctm_pkg::OFF_CMPA_LO, 8'h05);
    wr(ctm_pkg::OFF_CMPA_HI, 8'h00);
    wr(ctm_pkg::OFF_INT_STAT, 8'h03);
    wr(ctm_pkg::OFF_CTRL1, 8'h19);
    wr(ctm_pkg::OFF_CTRL0, 8'h48);
    @(negedge mclk);
    check("pin initial", 32'h1, {31'h0, timerOutputPin});
    pulse(2, 5);
    rdCount(rd);
    check("compare clears", 32'h0, rd);
    check("pin on match", 32'h0, {31'h0, timerOutputPin});
    rdReg(ctm_pkg::OFF_INT_STAT, rd);
    check("compare status", 32'h2, rd & 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(ctm_pkg::OFF_CTRL0, 8'h40);
      wr(ctm_pkg::OFF_CTRL1, ioCfg[k]);
      wr(ctm_pkg::OFF_CTRL0, 8'h48);
      pulse(2, 5);
      check("pin action", 32'(ioExp[k]), {31'h0, timerOutputPin});
    end
    wr(ctm_pkg::OFF_CTRL0, 8'h40);
    wr(ctm_pkg::OFF_CTRL1, 8'hD9);
    wr(ctm_pkg::OFF_CTRL0, 8'h48);
    @(negedge mclk);
    check("timer mode pin", 32'h0, {31'h0, timerOutputPin});
    end_sim();
  end
endmodule : compact_timer_module_regs_bench
`default_nettype wire
